// ===== core/link_cfg.sv
// Link mode decode, alignment-sequence parameter octets and link start sequencing.
// Assumes sys_clk at 100 MHz; all inputs synchronous; sync_n low requests resync.
`timescale 1ns/100ps
`default_nettype none
`include "link_cfg_defs.svh"
module link_cfg (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire link_cfg_pkg::link_mode_t link_mode_select,
  input  wire logic [7:0]              frames_per_multiframe_minus_one,
  input  wire logic [1:0]              single_input_select,
  input  wire logic [7:0]              device_id,
  input  wire logic                    scrambler_en,
  input  wire logic                    enc_64b66b,
  input  wire logic                    link_en,
  input  wire logic                    sync_n,
  output logic                         mode_valid,
  output logic                         interleave_flag,
  output logic                         dual_input_interleave,
  output logic                         sample_both_phases,
  output logic                         sel_analog_input_b,
  output logic [2:0]                   lane_bits_code,
  output logic                         pll_bypass,
  output logic [1:0]                   links,
  output logic [4:0]                   res_n,
  output logic [4:0]                   res_nprime,
  output logic [3:0]                   conv_m,
  output logic [3:0]                   lanes_l,
  output logic [3:0]                   octets_f,
  output logic [3:0]                   samples_s,
  output logic [8:0]                   frames_k,
  output logic [7:0]                   blocks_e,
  output logic                         cgs_active,
  output logic                         ilas_active,
  output logic                         data_active,
  output logic [7:0]                   ilas_octet,
  output logic                         ilas_valid,
  input  wire logic                    ilas_ready,
  output logic [7:0]                   ilas_checksum
);
  import link_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Mode table decode
  // ---------------------------------------------------------------
  // r_code: 0=0.625 1=1.25 2=2 3=2.5 4=4 5=5 (bits per lane per clock)
  function automatic mode_row_t decode_mode(input link_mode_t md);
    mode_row_t r;
    r = '0;
    unique case (md)
      5'h00: r = '{1'h1, 1'h1, 3'h4, 5'h0c, 1'h0, 5'h0c, 4'h4, 4'h4, 4'h8, 4'h5, 1'h0};
      5'h01: r = '{1'h1, 1'h1, 3'h2, 5'h0c, 1'h0, 5'h0c, 4'h8, 4'h8, 4'h8, 4'h5, 1'h0};
      5'h02: r = '{1'h1, 1'h0, 3'h4, 5'h0c, 1'h0, 5'h0c, 4'h4, 4'h4, 4'h8, 4'h5, 1'h0};
      5'h03: r = '{1'h1, 1'h0, 3'h2, 5'h0c, 1'h0, 5'h0c, 4'h8, 4'h8, 4'h8, 4'h5, 1'h0};
      5'h05: r = '{1'h1, 1'h1, 3'h3, 5'h08, 1'h0, 5'h08, 4'h4, 4'h1, 4'h1, 4'h4, 1'h0};
      5'h06: r = '{1'h1, 1'h1, 3'h1, 5'h08, 1'h0, 5'h08, 4'h8, 4'h1, 4'h1, 4'h8, 1'h0};
      5'h07: r = '{1'h1, 1'h0, 3'h3, 5'h08, 1'h0, 5'h08, 4'h4, 4'h1, 4'h1, 4'h4, 1'h0};
      5'h08: r = '{1'h1, 1'h0, 3'h1, 5'h08, 1'h0, 5'h08, 4'h8, 4'h1, 4'h1, 4'h8, 1'h0};
      5'h0a: r = '{1'h1, 1'h0, 3'h5, 5'h0f, 1'h1, 5'h10, 4'h2, 4'h2, 4'h2, 4'h1, 1'h0};
      5'h0b: r = '{1'h1, 1'h0, 3'h3, 5'h0f, 1'h1, 5'h10, 4'h4, 4'h2, 4'h2, 4'h2, 1'h0};
      5'h0c: r = '{1'h1, 1'h0, 3'h1, 5'h0f, 1'h1, 5'h10, 4'h8, 4'h2, 4'h2, 4'h4, 1'h0};
      5'h0d: r = '{1'h1, 1'h0, 3'h5, 5'h0f, 1'h1, 5'h10, 4'h1, 4'h2, 4'h4, 4'h1, 1'h0};
      5'h0e: r = '{1'h1, 1'h0, 3'h3, 5'h0f, 1'h1, 5'h10, 4'h2, 4'h2, 4'h2, 4'h1, 1'h0};
      5'h0f: r = '{1'h1, 1'h0, 3'h1, 5'h0f, 1'h1, 5'h10, 4'h4, 4'h2, 4'h2, 4'h2, 1'h0};
      5'h10: r = '{1'h1, 1'h0, 3'h0, 5'h0f, 1'h1, 5'h10, 4'h8, 4'h2, 4'h2, 4'h4, 1'h0};
      5'h13: r = '{1'h1, 1'h1, 3'h3, 5'h0c, 1'h0, 5'h0c, 4'h6, 4'h1, 4'h2, 4'h8, 1'h1};
      5'h14: r = '{1'h1, 1'h0, 3'h3, 5'h0c, 1'h0, 5'h0c, 4'h6, 4'h1, 4'h2, 4'h8, 1'h1};
      5'h15: r = '{1'h1, 1'h1, 3'h5, 5'h0f, 1'h1, 5'h10, 4'h2, 4'h1, 4'h2, 4'h2, 1'h0};
      5'h16: r = '{1'h1, 1'h1, 3'h3, 5'h0f, 1'h1, 5'h10, 4'h4, 4'h1, 4'h2, 4'h4, 1'h0};
      5'h17: r = '{1'h1, 1'h1, 3'h5, 5'h0f, 1'h1, 5'h10, 4'h1, 4'h1, 4'h2, 4'h1, 1'h0};
      5'h18: r = '{1'h1, 1'h1, 3'h3, 5'h0f, 1'h1, 5'h10, 4'h2, 4'h1, 4'h2, 4'h2, 1'h0};
      5'h19: r = '{1'h1, 1'h1, 3'h1, 5'h0f, 1'h1, 5'h10, 4'h8, 4'h1, 4'h2, 4'h8, 1'h0};
      5'h1a: r = '{1'h1, 1'h1, 3'h1, 5'h0f, 1'h1, 5'h10, 4'h4, 4'h1, 4'h2, 4'h4, 1'h0};
      5'h1b: r = '{1'h1, 1'h1, 3'h0, 5'h0f, 1'h1, 5'h10, 4'h8, 4'h1, 4'h2, 4'h8, 1'h0};
      default: r = '0;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Registered derived parameters
  // ---------------------------------------------------------------
  mode_row_t row_next;
  mode_row_t row_reg;
  logic      both_inputs;

  assign row_next    = decode_mode(link_mode_select);
  assign both_inputs = single_input_select == `MUX_BOTH;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_reg <= '0;
    end else begin
      row_reg <= row_next;
    end
  end

  assign mode_valid      = row_reg.valid;
  assign interleave_flag = row_reg.des;
  assign lane_bits_code  = row_reg.r_code;
  // Rates below two bits per clock (codes 0 and 1) are produced by dividing the clock, so the PLL is bypassed
  assign pll_bypass      = row_reg.valid &&
                           (row_reg.r_code == 3'h0 || row_reg.r_code == 3'h1);
  assign links           = row_reg.valid ? 2'h2 : 2'h0;
  assign res_n           = row_reg.n;
  assign res_nprime      = row_reg.nprime;
  assign conv_m          = row_reg.m;
  assign lanes_l         = row_reg.l;
  assign octets_f        = row_reg.f;
  assign samples_s       = row_reg.s;

  // ---------------------------------------------------------------
  // Interleaved dual-input control
  // ---------------------------------------------------------------
  logic dual_reg;
  logic phase_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dual_reg <= `ZERO_BIT;
    end else begin
      dual_reg <= row_next.valid && row_next.des && both_inputs;
    end
  end

  // Phase toggles each clock: channel B samples on the opposite half
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= `ZERO_BIT;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  assign dual_input_interleave = dual_reg;
  assign sample_both_phases    = row_reg.des;
  // Downstream sees one stream either way; only the input mux differs
  assign sel_analog_input_b    = dual_reg ? phase_reg : single_input_select[0];

  // ---------------------------------------------------------------
  // K and E
  // ---------------------------------------------------------------
  logic [8:0] k_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      k_reg <= 9'h000;
    end else begin
      k_reg <= enc_64b66b ? 9'h000 : {1'b0, frames_per_multiframe_minus_one} + 9'h001;
    end
  end

  assign frames_k = k_reg;
  assign blocks_e = enc_64b66b ? `E_FIXED : 8'h00;

  // ---------------------------------------------------------------
  // Alignment sequence octets
  // ---------------------------------------------------------------
  function automatic octet_t ilas_byte(input logic [3:0] idx, input mode_row_t r,
                                       input logic [7:0] did, input logic [7:0] km1,
                                       input logic scr);
    octet_t o;
    o = 8'h00;
    unique case (idx)
      4'h0: o = did;
      4'h1: o = 8'h00;
      4'h2: o = 8'h00;
      4'h3: o = {scr, 3'h0, r.l - 4'h1};
      4'h4: o = {4'h0, r.f - 4'h1};
      4'h5: o = {3'h0, km1[4:0]};
      4'h6: o = {4'h0, r.m - 4'h1};
      4'h7: o = {3'h0, r.n - 5'h01};
      4'h8: o = {`SUBCLASSV_VAL, r.nprime - 5'h01};
      4'h9: o = {`JESDV_VAL, 1'b0, r.s - 4'h1};
      4'ha: o = 8'h00;
      4'hb: o = 8'h00;
      4'hc: o = 8'h00;
      default: o = 8'h00;
    endcase
    return o;
  endfunction

  logic [7:0] sum_w [`ILAS_OCTETS];
  genvar gi;
  generate
    for (gi = 0; gi < `ILAS_OCTETS - 1; gi++) begin : g_sum
      if (gi == 0) begin : g_first
        assign sum_w[gi] = ilas_byte(4'(gi), row_reg, device_id,
                                     frames_per_multiframe_minus_one, scrambler_en);
      end else begin : g_rest
        assign sum_w[gi] = sum_w[gi-1] + ilas_byte(4'(gi), row_reg, device_id,
                                     frames_per_multiframe_minus_one, scrambler_en);
      end
    end
  endgenerate
  assign sum_w[`ILAS_OCTETS-1] = sum_w[`ILAS_OCTETS-2];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ilas_checksum <= 8'h00;
    end else begin
      ilas_checksum <= sum_w[`ILAS_OCTETS-1];
    end
  end

  // ---------------------------------------------------------------
  // Link start sequencing
  // ---------------------------------------------------------------
  link_state_t state_reg;
  link_state_t state_next;
  logic [3:0]  idx_reg;
  logic        push;
  logic        fifo_in_ready;
  octet_t      push_octet;

  assign push = state_reg == ST_ILAS && fifo_in_ready;
  assign push_octet = (idx_reg == `ILAS_LAST_IDX) ? ilas_checksum :
                      ilas_byte(idx_reg, row_reg, device_id,
                                frames_per_multiframe_minus_one, scrambler_en);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (link_en && row_reg.valid) state_next = enc_64b66b ? ST_DATA : ST_CGS;
      ST_CGS:  if (sync_n) state_next = ST_ILAS;
      ST_ILAS: if (push && idx_reg == `ILAS_LAST_IDX) state_next = ST_DATA;
      ST_DATA: if (!enc_64b66b && !sync_n) state_next = ST_CGS;
    endcase
    if (!link_en) state_next = ST_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= 4'h0;
    end else if (state_reg != ST_ILAS) begin
      idx_reg <= 4'h0;
    end else if (push) begin
      idx_reg <= idx_reg + 4'h1;
    end
  end

  assign cgs_active  = state_reg == ST_CGS;
  assign ilas_active = state_reg == ST_ILAS;
  assign data_active = state_reg == ST_DATA;

  // ---------------------------------------------------------------
  // Octet buffer toward the lane framer
  // ---------------------------------------------------------------
  octet_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (state_reg == ST_ILAS),
    .in_ready  (fifo_in_ready),
    .in_data   (push_octet),
    .out_valid (ilas_valid),
    .out_ready (ilas_ready),
    .out_data  (ilas_octet)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_sync_release;
    state_reg == ST_CGS && link_en ##1 state_reg == ST_CGS && sync_n && link_en;
  endsequence

  a_des_flag_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_valid |-> interleave_flag == $past(row_next.des))
    else $error("interleave flag does not follow mode");
  a_sync_to_ilas: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_sync_release |=> state_reg == ST_ILAS)
    else $error("sync release did not start alignment");
  a_no_ilas_64b: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(enc_64b66b) && enc_64b66b && $past(state_reg) == ST_IDLE |-> state_reg != ST_CGS)
    else $error("alignment started in 64b66b");
  a_e_fixed_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enc_64b66b |-> blocks_e == 8'h01)
    else $error("E not one");
  a_k_from_km1: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) && !$past(enc_64b66b) |->
      frames_k == {1'b0, $past(frames_per_multiframe_minus_one)} + 9'h001)
    else $error("K does not match field");
  a_dual_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dual_input_interleave |=> sel_analog_input_b != $past(sel_analog_input_b) || !dual_input_interleave)
    else $error("interleaved inputs not alternating");
  a_pll_bypass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lane_bits_code >= 3'h2 |-> !pll_bypass)
    else $error("pll bypass with integer rate");
  a_sum_mod: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> ilas_checksum == $past(sum_w[`ILAS_OCTETS-1]))
    else $error("checksum mismatch");

  // ---------------------------------------------------------------
  // Refusal and hold checks
  // ---------------------------------------------------------------
  // Stated per rule rather than through the decode function
  sequence s_ilas_last;
    state_reg == ST_ILAS && push && idx_reg == `ILAS_LAST_IDX && link_en;
  endsequence

  a_ilas_end_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ilas_last |=> data_active)
    else $error("alignment end did not enter data");
  a_reserved_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) && !$past(mode_valid) && $past(state_reg) == ST_IDLE |-> state_reg == ST_IDLE)
    else $error("link left idle with reserved mode");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !mode_valid |-> !pll_bypass && links == 2'h0 && !interleave_flag)
    else $error("reserved mode reports nonzero fields");
  a_links_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_valid |-> links == 2'h2)
    else $error("link count wrong");
  a_bypass_frac: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_valid && lane_bits_code <= 3'h1 |-> pll_bypass)
    else $error("fractional rate without pll bypass");
  a_e_zero_8b: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !enc_64b66b |-> blocks_e == 8'h00)
    else $error("E used in 8b10b");
  a_k_zero_64b: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) && $past(enc_64b66b) |-> frames_k == 9'h000)
    else $error("K used in 64b66b");
  a_cgs_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cgs_active && link_en && !sync_n |=> cgs_active)
    else $error("left sync while request held");
  a_resync_cgs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(data_active) && !$past(enc_64b66b) && !$past(sync_n) && $past(link_en) |-> cgs_active)
    else $error("sync request in data did not restart sync");
  a_dual_needs_des: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dual_input_interleave |-> interleave_flag && mode_valid)
    else $error("dual input outside single-channel mode");
  a_data_hold_64b: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_active && enc_64b66b && link_en |=> data_active)
    else $error("64b66b link left data");
endmodule
`default_nettype wire

// ===== core/link_cfg_defs.svh
// Constants for the serial link mode and parameter configuration block.
// Assumes inclusion by bare name from core/ files; definitions only.
// Function
// - Interleaved dual-input mode samples twice per clock, channels out of phase.
// - Interleaved mode processes data exactly like ordinary single-channel mode.
// - Framing parameters other than K and E derive from the link mode select value.
// - Interleave flag is 1 for single-channel modes, 0 for dual-channel.
// - R bits per lane per clock set PLL multiplier or bypass.
// - K comes from the minus-one field, used only in 8B/10B.
// - E is fixed at one, used only in 64B/66B.
// - 8B/10B sends alignment sequence; 64B/66B sends none but frames alike.
// - ADJCNT, ADJDIR, BID, CF, HD, RES1, RES2 are reported as zero.
// - Control-bits-per-sample reported as zero even when samples carry control.
// - JESDV and SUBCLASSV are reported as one.
// - DID comes from a user field and identifies the link.
// - SCR follows the user scrambler enable bit.
// - Checksum is the sum of parameter octets 0 to 12 modulo 256.
// - M is derived from the mode for lane packing.
// - N and N' are derived from the mode.
// - In 8B/10B, receiver sync request starts code group sync and alignment sequence; 64B/66B ignores it.
`ifndef LINK_CFG_DEFS_SVH
`define LINK_CFG_DEFS_SVH

`define MODE_W          5
`define NUM_MODES       28
`define ILAS_OCTETS     14
`define ILAS_LAST_IDX   4'hd
`define FIFO_DEPTH      4
`define ONE_BIT         1'h1
`define ZERO_BIT        1'h0
`define JESDV_VAL       3'h1
`define SUBCLASSV_VAL   3'h1
`define E_FIXED         8'h01
`define MUX_BOTH        2'h3

`endif

// ===== core/link_cfg_pkg.sv
// Types shared by the link configuration block.
// Assumes link_cfg_defs.svh is on the include path.
package link_cfg_pkg;
  typedef logic [4:0] link_mode_t;
  typedef logic [7:0] octet_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CGS  = 2'b01,
    ST_ILAS = 2'b10,
    ST_DATA = 2'b11
  } link_state_t;
  typedef struct packed {
    logic       valid;
    logic       des;
    logic [2:0] r_code;
    logic [4:0] n;
    logic       cs;
    logic [4:0] nprime;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic       hd;
  } mode_row_t;
endpackage

// ===== core/octet_fifo.sv
// Small synchronous FIFO for the alignment-sequence octet stream.
// Assumes one clock; width and depth are parameters, depth a power of two.
`timescale 1ns/100ps
`default_nettype none
module octet_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointers carry one extra bit so full and empty differ without a flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  always_comb begin
    out_data = mem_reg[rd_ptr_reg[AW-1:0]];
  end

  a_fifo_no_overflow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ptr_reg - rd_ptr_reg) <= (AW+1)'(DEPTH))
    else $error("fifo occupancy beyond depth");
endmodule
`default_nettype wire

// ===== dv/link_cfg_tb.sv
// Self-checking bench for the link configuration block and its octet FIFO.
// Assumes link_rx_model plays the receiver; expectations come from a mode table here.
`timescale 1ns/100ps
`default_nettype none
module link_cfg_tb;
  import link_cfg_pkg::*;
  logic sys_clk, rst_n, scrambler_en, enc_64b66b, link_en, hold_sync, stall_all;
  link_mode_t link_mode_select;
  logic [7:0] km1, device_id, ilas_octet, ilas_checksum;
  logic [1:0] single_input_select, links;
  logic mode_valid, interleave_flag, dual_input_interleave, sample_both_phases;
  logic sel_analog_input_b, pll_bypass, cgs_active, ilas_active, data_active;
  logic ilas_valid, ilas_ready, sync_n, sel_prev;
  logic [2:0] lane_bits_code;
  logic [4:0] res_n, res_nprime;
  logic [3:0] conv_m, lanes_l, octets_f, samples_s;
  logic [8:0] frames_k;
  logic [7:0] blocks_e;
  int fails, n_tests, i, j, seed;
  int md_list[15] = '{0, 2, 4, 5, 6, 7, 9, 10, 13, 16, 17, 19, 21, 27, 28};
  logic [43:0] r;
  logic [7:0] exp_o[14];
  logic [7:0] sum;

  link_cfg u_link_cfg (.sys_clk(sys_clk), .rst_n(rst_n), .link_mode_select(link_mode_select),
    .frames_per_multiframe_minus_one(km1), .single_input_select(single_input_select),
    .device_id(device_id), .scrambler_en(scrambler_en), .enc_64b66b(enc_64b66b),
    .link_en(link_en), .sync_n(sync_n), .mode_valid(mode_valid),
    .interleave_flag(interleave_flag), .dual_input_interleave(dual_input_interleave),
    .sample_both_phases(sample_both_phases), .sel_analog_input_b(sel_analog_input_b),
    .lane_bits_code(lane_bits_code), .pll_bypass(pll_bypass), .links(links), .res_n(res_n),
    .res_nprime(res_nprime), .conv_m(conv_m), .lanes_l(lanes_l), .octets_f(octets_f),
    .samples_s(samples_s), .frames_k(frames_k), .blocks_e(blocks_e),
    .cgs_active(cgs_active), .ilas_active(ilas_active), .data_active(data_active),
    .ilas_octet(ilas_octet), .ilas_valid(ilas_valid), .ilas_ready(ilas_ready),
    .ilas_checksum(ilas_checksum));

  link_rx_model u_link_rx_model (.sys_clk(sys_clk), .rst_n(rst_n), .ilas_octet(ilas_octet),
    .ilas_valid(ilas_valid), .hold_sync(hold_sync), .stall_all(stall_all),
    .ilas_ready(ilas_ready), .sync_n(sync_n));

  // ----------------------------------------
  // Reference mode table
  // ----------------------------------------
  // Packed as valid, des, n, n', l, m, f, s, lane-bits code; reserved rows are all zero
  function automatic logic [43:0] row(input int md);
    case (md)
      0:  return 44'h1_1_0c_0c_4_4_8_5_4;
      2:  return 44'h1_0_0c_0c_4_4_8_5_4;
      5:  return 44'h1_1_08_08_4_1_1_4_3;
      6:  return 44'h1_1_08_08_8_1_1_8_1;
      7:  return 44'h1_0_08_08_4_1_1_4_3;
      10: return 44'h1_0_0f_10_2_2_2_1_5;
      13: return 44'h1_0_0f_10_1_2_4_1_5;
      16: return 44'h1_0_0f_10_8_2_2_4_0;
      19: return 44'h1_1_0c_0c_6_1_2_8_3;
      21: return 44'h1_1_0f_10_2_1_2_2_5;
      27: return 44'h1_1_0f_10_8_1_2_8_0;
      default: return 44'h0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Whole run needs well under a thousand cycles; this leaves wide margin
  initial begin
    #50us;
    fails++;
    end_sim();
  end

  initial begin
    seed = 32'h4ee3dc72;
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    link_mode_select = 5'h00;
    km1 = 8'h0f;
    single_input_select = 2'h0;
    device_id = 8'h5c;
    scrambler_en = 1'b0;
    enc_64b66b = 1'b0;
    link_en = 1'b1;
    hold_sync = 1'b1;
    stall_all = 1'b1;
    cyc(8);
    chk("reset mode_valid", 16'h0, mode_valid);
    chk("reset cgs_active", 16'h0, cgs_active);
    chk("reset ilas_valid", 16'h0, ilas_valid);
    cyc(8);
    rst_n = 1'b1;
    link_en = 1'b0;
    cyc(2);
    // ----------------------------------------
    // Mode decode across valid and reserved modes
    // ----------------------------------------
    for (i = 0; i < 15; i++) begin
      r = row(md_list[i]);
      link_mode_select = md_list[i][4:0];
      km1 = $random(seed);
      single_input_select = $random(seed);
      enc_64b66b = $random(seed);
      cyc(3);
      chk("mode_valid", r[43:40], mode_valid);
      chk("interleave_flag", r[39:36], interleave_flag);
      chk("sample_both_phases", r[39:36], sample_both_phases);
      chk("dual_input_interleave", r[39:36] & (single_input_select == 2'h3),
          dual_input_interleave);
      chk("res_n", r[35:28], res_n);
      chk("res_nprime", r[27:20], res_nprime);
      chk("lanes_l", r[19:16], lanes_l);
      chk("conv_m", r[15:12], conv_m);
      chk("octets_f", r[11:8], octets_f);
      chk("samples_s", r[7:4], samples_s);
      chk("lane_bits_code", r[3:0], lane_bits_code);
      chk("pll_bypass", r[40] & (r[3:0] < 4'h2), pll_bypass);
      chk("links", r[40] ? 16'h2 : 16'h0, links);
      if (r[40]) begin
        chk("frames_k", enc_64b66b ? 16'h0 : km1 + 16'h1, frames_k);
        chk("blocks_e", enc_64b66b ? 16'h1 : 16'h0, blocks_e);
      end
      sel_prev = sel_analog_input_b;
      cyc(1);
      if (r[39:36] == 4'h1 && single_input_select == 2'h3) begin
        chk("sel_b toggles", !sel_prev, sel_analog_input_b);
      end else begin
        chk("sel_b mux", single_input_select[0], sel_analog_input_b);
      end
    end
    // ----------------------------------------
    // Reserved mode keeps the link idle
    // ----------------------------------------
    link_mode_select = 5'h04;
    enc_64b66b = 1'b1;
    link_en = 1'b1;
    cyc(4);
    chk("reserved idle", 16'h0, {cgs_active, ilas_active, data_active});
    // ----------------------------------------
    // 64b/66b skips the alignment sequence
    // ----------------------------------------
    link_mode_select = 5'h0a;
    cyc(4);
    chk("64b data_active", 16'h1, data_active);
    chk("64b no octets", 16'h0, ilas_valid | (u_link_rx_model.rx_q.size() != 0));
    link_en = 1'b0;
    cyc(2);
    // ----------------------------------------
    // 8b/10b sync, stalled FIFO fill, then octet stream
    // ----------------------------------------
    link_mode_select = 5'h15;
    enc_64b66b = 1'b0;
    km1 = 8'h1f;
    device_id = $random(seed);
    scrambler_en = 1'b1;
    single_input_select = 2'h3;
    exp_o = '{device_id, 8'h00, 8'h00, 8'h81, 8'h01, 8'h1f, 8'h00, 8'h0e, 8'h2f, 8'h21,
              8'h00, 8'h00, 8'h00, 8'h00};
    sum = 8'h00;
    for (j = 0; j < 13; j++) sum = sum + exp_o[j];
    exp_o[13] = sum;
    link_en = 1'b1;
    cyc(5);
    chk("cgs while sync low", 16'h1, cgs_active);
    chk("no ilas while sync low", 16'h0, ilas_active | ilas_valid);
    chk("ilas_checksum", sum, ilas_checksum);
    chk("dual_input_interleave on", 16'h1, dual_input_interleave);
    sel_prev = sel_analog_input_b;
    cyc(1);
    chk("sel_b interleaved", !sel_prev, sel_analog_input_b);
    hold_sync = 1'b0;
    cyc(20);
    chk("fifo full stalls", 16'h3, {ilas_active, ilas_valid});
    chk("fifo full no data", 16'h0, data_active);
    stall_all = 1'b0;
    for (j = 0; j < 300 && !(data_active === 1'b1 && u_link_rx_model.rx_q.size() == 14); j++)
      cyc(1);
    chk("octet count", 16'd14, u_link_rx_model.rx_q.size());
    for (j = 0; j < 14 && j < u_link_rx_model.rx_q.size(); j++) begin
      chk($sformatf("octet %0d", j), exp_o[j], u_link_rx_model.rx_q[j]);
    end
    cyc(2);
    chk("fifo drained", 16'h0, ilas_valid);
    hold_sync = 1'b1;
    cyc(4);
    chk("resync to cgs", 16'h1, cgs_active);
    link_en = 1'b0;
    cyc(3);
    chk("disable idle", 16'h0, {cgs_active, ilas_active, data_active});
    end_sim();
  end
endmodule
`default_nettype wire

// ===== dv/link_rx_model.sv
// Behavioural link receiver facing the alignment-sequence octet stream.
// Assumes the bench drives hold_sync and stall_all off the rising edge.
`timescale 1ns/100ps
`default_nettype none
module link_rx_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] ilas_octet,
  input  wire logic       ilas_valid,
  input  wire logic       hold_sync,
  input  wire logic       stall_all,
  output logic            ilas_ready,
  output logic            sync_n
);
  logic [7:0] rx_q[$];
  int         seed = 32'h4ee3dc72;
  // Ready and sync move by non-blocking update at the rising edge, clear of bench stimulus
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ilas_ready <= 1'b0;
      sync_n     <= 1'b1;
    end else begin
      sync_n     <= !hold_sync;
      ilas_ready <= !stall_all && (($random(seed) & 3) != 0);
    end
  end
  // An octet counts only when valid and ready meet at a rising edge
  always @(posedge sys_clk) begin
    if (rst_n && ilas_valid && ilas_ready) begin
      rx_q.push_back(ilas_octet);
    end
  end
endmodule
`default_nettype wire
